// *** tb/rpi_host.sv ***
/* serial bus host model on the block's bus pins
   steps on core_clk falls; the data wire has a pull-up */
`timescale 1ns/100ps
module rpi_host #(
   parameter logic [6:0] ADDR = 7'h5A
) (
   // clock and data wire
   input  wire logic core_clk,
   input  wire logic sda,
   // driven pins, high means released
   output logic      scl,
   output logic      sda_drv
);
   // ----
   // bus cycles
   // ----
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic hold();
      repeat (3) @(negedge core_clk);
   endtask
   // data moves well after the clock fall so the slave never sees a false start
   task automatic bit_io(input logic b, output logic r);
      hold();
      sda_drv = b;
      hold();
      scl = 1'b1;
      hold();
      r = sda;
      scl = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(1'b1, ack);
   endtask
   task automatic cond(input logic first);
      hold();
      sda_drv = first;
      hold();
      scl = 1'b1;
      hold();
      sda_drv = !first;
      hold();
      if (first) scl = 1'b0;
   endtask
   task automatic write(input logic [7:0] p, input logic [7:0] d, output logic nak);
      logic [7:0] q;
      logic [2:0] a;
      cond(1'b1);
      xfer({ADDR, 1'b0}, q, a[0]);
      xfer(p, q, a[1]);
      xfer(d, q, a[2]);
      cond(1'b0);
      nak = |a;
   endtask
   task automatic read(input logic [7:0] p, output logic [7:0] d);
      logic [7:0] q;
      logic       a;
      cond(1'b1);
      xfer({ADDR, 1'b0}, q, a);
      xfer(p, q, a);
      cond(1'b1);
      xfer({ADDR, 1'b1}, q, a);
      xfer(8'hFF, d, a);
      cond(1'b0);
   endtask
endmodule

// *** tb/rpi_props.sv ***
/* pin checks of the periodic interrupt block
   sees only top ports; core and link clock domains */
`timescale 1ns/100ps
module rpi_props #(
   parameter int REL_SLOW = 20,
   parameter int REL_UPD  = 16
) (
   // clocks and reset
   input wire logic core_clk,
   input wire logic rst,
   input wire logic link_clk,
   // pins
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic int_in,
   input wire logic int_out,
   input wire logic int_oe_n
);
   // ----
   // helpers
   // ----
   // two pulses may overlap, plus the fixed fast release
   localparam int LIMIT = REL_SLOW + REL_UPD + 1228;
   logic [11:0] low_run;
   logic [3:0]  drv_bits;
   always_ff @(posedge core_clk) begin
      if (rst || int_oe_n) low_run <= 12'h000;
      else if (low_run != 12'hFFF) low_run <= low_run + 12'h001;
   end
   always_ff @(posedge link_clk) begin
      if (rst || sda_oe_n) drv_bits <= 4'h0;
      else if ($rose(scl_in) && drv_bits != 4'hF) drv_bits <= drv_bits + 4'h1;
   end
   sequence s_held;
      !int_oe_n [*3];
   endsequence
   a_int_od_low:
      assert property (@(posedge core_clk) int_out == 1'b0)
      else $error("interrupt data not low");
   a_sda_od_low:
      assert property (@(posedge link_clk) sda_out == 1'b0)
      else $error("bus data not low");
   a_reset_int_free:
      assert property (@(posedge core_clk) rst |=> int_oe_n)
      else $error("interrupt driven in reset");
   a_pulse_bound:
      assert property (@(posedge core_clk) disable iff (rst) int'(low_run) <= LIMIT)
      else $error("interrupt low too long");
   a_pulse_held:
      assert property (@(posedge core_clk) disable iff (rst) $fell(int_oe_n) |-> s_held)
      else $error("interrupt pulse too short");
   a_ack_scl_low:
      assert property (@(posedge link_clk) disable iff (rst) $fell(sda_oe_n) |-> !scl_in)
      else $error("data pulled while clock high");
   a_rel_scl_low:
      assert property (@(posedge link_clk) disable iff (rst) $rose(sda_oe_n) |-> !scl_in)
      else $error("data freed while clock high");
   a_drive_bound:
      assert property (@(posedge link_clk) disable iff (rst) drv_bits <= 4'h9)
      else $error("data held low too long");
endmodule
bind rpi_top rpi_props #(.REL_SLOW(REL_SLOW), .REL_UPD(REL_UPD)) i_props (
   .core_clk(core_clk), .rst(rst), .link_clk(link_clk), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .int_in(int_in),
   .int_out(int_out), .int_oe_n(int_oe_n));

// *** tb/rpi_top_test.sv ***
/* self-checking bench of the periodic interrupt block
   bus through the host model; pull-ups on both wires */
`timescale 1ns/100ps
module rpi_top_test;
   typedef struct packed {
      logic [7:0] ptr;
      logic [7:0] wdat;
      logic [7:0] exp;
   } rpi_row_type;
   localparam int REL = 400;
   // soft reset stays on while rows touch the enables
   rpi_row_type rows [9] = '{'{8'h0F, 8'h01, 8'h01}, '{8'h0E, 8'h00, 8'h00},
      '{8'h0E, 8'hFF, 8'h00}, '{8'h0B, 8'hA5, 8'hA5}, '{8'h0C, 8'hFF, 8'hFF},
      '{8'h0D, 8'hCE, 8'hCE}, '{8'h0F, 8'hFF, 8'hF9}, '{8'h0F, 8'h01, 8'h01},
      '{8'h03, 8'h55, 8'h00}};
   logic       core_clk = 1'b0;
   logic       link_clk = 1'b0;
   logic       rst = 1'b1;
   logic       scl, host_sda, sda_out, sda_oe_n, int_out, int_oe_n, nak;
   logic [7:0] rd;
   wire        sda_w = host_sda & (sda_oe_n | sda_out);
   wire        int_w = int_oe_n | int_out;
   int         n_mismatch = 0;
   int         num_checks = 0;
   int         run = 0;
   int         last_len = 0;
   int         n_fall = 0;
   int         nf;
   time        t0, t1, tw;
   always #50 core_clk = ~core_clk;
   initial #3 forever #7.5 link_clk = ~link_clk;
   rpi_top #(.TICK_DIV(16), .TICKS_PER_SEC(64), .REL_SLOW(REL), .REL_UPD(REL)) i_dut (
      .core_clk(core_clk), .rst(rst), .link_clk(link_clk), .scl_in(scl),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .int_in(int_w),
      .int_out(int_out), .int_oe_n(int_oe_n));
   rpi_host i_host (.core_clk(core_clk), .sda(sda_w), .scl(scl), .sda_drv(host_sda));
   always @(posedge core_clk) begin
      if (int_oe_n === 1'b0) begin
         if (run == 0) begin
            n_fall++;
            t0 = t1;
            t1 = $time;
         end
         run++;
      end else if (run != 0) begin
         last_len = run;
         run = 0;
      end
   end
   // ----
   // tasks
   // ----
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic wr(logic [7:0] p, logic [7:0] d);
      i_host.write(p, d, nak);
      check("ack", nak, 32'h0);
   endtask
   task automatic rdc(string what, logic [7:0] p, logic [7:0] e);
      i_host.read(p, rd);
      check(what, rd, e);
   endtask
   task automatic wait_fall();
      int n0;
      n0 = n_fall;
      for (int i = 0; i < 3000 && n_fall == n0; i++) @(negedge core_clk);
      check("int fall", n_fall - n0, 32'h1);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #8_000_000;
      n_mismatch++;
      complete_run();
   end
   initial begin
      repeat (2) @(negedge core_clk);
      rst = 1'b0;
      repeat (10) @(negedge core_clk);
      check("pin idle", int_oe_n, 32'h1);
      rdc("ext reset", 8'h0D, rpi_pkg::REG_RESET);
      rdc("ctrl reset", 8'h0F, rpi_pkg::REG_RESET);
      foreach (rows[i]) begin
         wr(rows[i].ptr, rows[i].wdat);
         rdc("row", rows[i].ptr, rows[i].exp);
      end
      wr(8'h0D, 8'h00);
      wr(8'h0F, 8'h00);
      wr(8'h0E, 8'h00);
      repeat (1100) @(negedge core_clk);
      rdc("masked flag", 8'h0E, 8'h20);
      check("masked pin", n_fall, 32'h0);
      wr(8'h0F, 8'h20);
      wait_fall();
      wr(8'h0E, 8'h00);
      check("pin after clear", int_oe_n, 32'h0);
      wait_fall();
      check("update len", last_len inside {[REL - 1:REL + 1]}, 32'h1);
      check("second", 32'((t1 - t0) / 100), 32'h400);
      wr(8'h0F, 8'h00);
      check("update cut", int_oe_n, 32'h1);
      wr(8'h0F, 8'h01);
      wr(8'h0E, 8'h00);
      repeat (2200) @(negedge core_clk);
      rdc("soft reset", 8'h0E, 8'h00);
      wr(8'h0F, 8'h00);
      wr(8'h0B, 8'h02);
      wr(8'h0C, 8'h00);
      wr(8'h0F, 8'h10);
      wr(8'h0D, 8'h11);
      tw = $time;
      wait_fall();
      check("first", 32'((t1 - tw) / 100) inside {[990:2048]}, 32'h1);
      wr(8'h0E, 8'h00);
      check("pin after tf", int_oe_n, 32'h0);
      wait_fall();
      check("interval", 32'((t1 - t0) / 100), 32'h800);
      check("timer len", last_len inside {[REL - 1:REL + 1]}, 32'h1);
      wr(8'h0F, 8'h00);
      check("timer cut", int_oe_n, 32'h1);
      rdc("tf held", 8'h0E, 8'h30);
      nf = n_fall;
      wr(8'h0E, 8'h00);
      repeat (2200) @(negedge core_clk);
      rdc("tf masked", 8'h0E, 8'h30);
      check("no timer pin", n_fall - nf, 32'h0);
      wr(8'h0D, 8'h01);
      wr(8'h0E, 8'h00);
      repeat (2200) @(negedge core_clk);
      rdc("stopped", 8'h0E, 8'h20);
      wr(8'h0F, 8'h21);
      rst = 1'b1;
      repeat (2) @(negedge core_clk);
      rst = 1'b0;
      repeat (10) @(negedge core_clk);
      check("pin after rst", int_oe_n, 32'h1);
      rdc("ctrl after rst", 8'h0F, rpi_pkg::REG_RESET);
      complete_run();
   end
endmodule

// *** verilog/rpi_pkg.sv ***
/*
 * Constants, types and register map of the periodic interrupt block.
 * Assumes a 10 MHz core clock and a two-wire serial host bus.
 */
package rpi_pkg;
   // ------------------------------------------------------------
   // register indices
   // ------------------------------------------------------------
   localparam logic [3:0] REG_TCNT0 = 4'hB;
   localparam logic [3:0] REG_TCNT1 = 4'hC;
   localparam logic [3:0] REG_EXT   = 4'hD;
   localparam logic [3:0] REG_FLAG  = 4'hE;
   localparam logic [3:0] REG_CTRL  = 4'hF;
   localparam logic [3:0] PTR_STEP  = 4'h1;

   // ------------------------------------------------------------
   // field positions, masks, reset values
   // ------------------------------------------------------------
   localparam int EXT_UPDATE_PERIOD_SELECT  = 5;
   localparam int EXT_TE    = 4;
   localparam int EXT_TSEL  = 0;
   localparam int FLAG_UF   = 5;
   localparam int FLAG_TF   = 4;
   localparam int CTRL_UIE  = 5;
   localparam int CTRL_TIE  = 4;
   localparam int CTRL_SRST = 0;
   localparam logic [7:0] CTRL_MASK = 8'hF9;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [3:0] PRESET_HI = 4'hF;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam longint CORE_HZ      = 10_000_000;
   localparam longint SRC_FAST_HZ  = 4096;
   localparam longint SRC_SLOW_HZ  = 64;
   localparam longint SEC_PER_MIN  = 60;
   localparam longint REL_FAST_NS  = 122_000;
   localparam longint REL_SLOW_NS  = 7_800_000;
   localparam longint REL_UPD_NS   = 7_182_500;
   localparam longint NS_PER_S     = 1_000_000_000;
   localparam longint TICK_DIV_CYC = CORE_HZ / SRC_FAST_HZ;
   localparam longint TICKS_64     = SRC_FAST_HZ / SRC_SLOW_HZ;
   localparam longint REL_FAST_CYC = REL_FAST_NS * CORE_HZ / NS_PER_S;
   localparam longint REL_SLOW_CYC = REL_SLOW_NS * CORE_HZ / NS_PER_S;
   localparam longint REL_UPD_CYC  = REL_UPD_NS * CORE_HZ / NS_PER_S;
   localparam int     REL_W        = 17;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_4096 = 2'b00,
      SRC_64   = 2'b01,
      SRC_SEC  = 2'b10,
      SRC_MIN  = 2'b11
   } rpi_src_type;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_PTR   = 3'b010,
      ST_WDATA = 3'b011,
      ST_ACK   = 3'b100,
      ST_RDATA = 3'b101,
      ST_RACK  = 3'b110
   } rpi_bus_state_type;

   typedef struct packed {
      logic        te;
      logic        timer_irq_enable;
      logic        update_irq_enable;
      logic        update_period_select;
      rpi_src_type tsel;
      logic        srst;
      logic [11:0] preset;
   } rpi_cfg_type;
endpackage

// *** verilog/rpi_top.sv ***
/*
 * Periodic timer and time update interrupt logic with its serial
 * register slave. The slave runs on link_clk and samples the bus
 * pins; counting and the interrupt pin run on core_clk.
 * Assumes an external pull-up on the data and interrupt wires.
 */
`timescale 1ns/100ps
module rpi_top #(
   parameter int     BUS_ADDR      = 7'h5A,
   parameter int     TICK_DIV      = int'(rpi_pkg::TICK_DIV_CYC),
   parameter int     TICKS_PER_SEC = int'(rpi_pkg::SRC_FAST_HZ),
   parameter int     REL_SLOW      = int'(rpi_pkg::REL_SLOW_CYC),
   parameter int     REL_UPD       = int'(rpi_pkg::REL_UPD_CYC)
) (
   // core clock and reset
   input  wire logic core_clk,
   input  wire logic rst,
   // link clock
   input  wire logic link_clk,
   // serial bus pins
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe_n,
   // interrupt pin
   input  wire logic int_in,
   output logic      int_out,
   output logic      int_oe_n
);
   // ------------------------------------------------------------
   // parameter checks
   // ------------------------------------------------------------
   initial begin
      if (TICK_DIV < 2 || TICK_DIV > 4096)
         $error("TICK_DIV out of range");
      if (TICKS_PER_SEC < 64 || TICKS_PER_SEC > 8191)
         $error("TICKS_PER_SEC out of range");
      if (REL_SLOW < 2 || REL_SLOW >= (1 << rpi_pkg::REL_W))
         $error("REL_SLOW out of range");
      if (REL_UPD < 2 || REL_UPD >= (1 << rpi_pkg::REL_W))
         $error("REL_UPD out of range");
      if (BUS_ADDR > 127)
         $error("BUS_ADDR must fit seven bits");
   end

   localparam logic [6:0]  ADDR7   = 7'(BUS_ADDR);
   localparam logic [11:0] TDIV_M1 = 12'(TICK_DIV - 1);
   localparam logic [12:0] SEC_M1  = 13'(TICKS_PER_SEC - 1);
   localparam logic [5:0]  T64_M1  = 6'(rpi_pkg::TICKS_64 - 1);
   localparam logic [5:0]  MIN_M1  = 6'(rpi_pkg::SEC_PER_MIN - 1);
   localparam logic [16:0] RL_FAST = 17'(rpi_pkg::REL_FAST_CYC);
   localparam logic [16:0] RL_SLOW = 17'(REL_SLOW);
   localparam logic [16:0] RL_UPD  = 17'(REL_UPD);
   localparam logic [16:0] RL_ONE  = 17'h00001;
   localparam logic [11:0] CNT_ONE = 12'h001;
   localparam logic [3:0]  BIT_END = 4'h7;
   localparam logic [3:0]  BIT_ONE = 4'h1;

   // ------------------------------------------------------------
   // state types
   // ------------------------------------------------------------
   typedef struct packed {
      logic                       rst_m;
      logic                       rst_s;
      logic                       scl_m;
      logic                       scl_s;
      logic                       scl_d;
      logic                       sda_m;
      logic                       sda_s;
      logic                       sda_d;
      logic                       tev_m;
      logic                       tev_s;
      logic                       tev_d;
      logic                       uev_m;
      logic                       uev_s;
      logic                       uev_d;
      rpi_pkg::rpi_bus_state_type st;
      rpi_pkg::rpi_bus_state_type nxt;
      logic                       ackon;
      logic                       rw;
      logic [3:0]                 bc;
      logic [7:0]                 sh;
      logic [3:0]                 ptr;
      logic                       drv;
      logic [7:0]                 tcnt0;
      logic [7:0]                 tcnt1;
      logic [7:0]                 ext;
      logic [7:0]                 ctrl;
      logic                       tflag;
      logic                       uflag;
      logic                       stg;
   } rpi_link_type;

   typedef struct packed {
      rpi_pkg::rpi_cfg_type cfg_m;
      rpi_pkg::rpi_cfg_type cfg_s;
      logic                 stg_m;
      logic                 stg_s;
      logic                 stg_d;
      logic [11:0]          tick_cnt;
      logic [5:0]           t64_cnt;
      logic [12:0]          sec_cnt;
      logic [5:0]           min_cnt;
      logic [11:0]          cnt;
      logic                 tmr_low;
      logic [16:0]          tmr_rel;
      logic                 upd_low;
      logic [16:0]          upd_rel;
      logic                 tev_tgl;
      logic                 uev_tgl;
   } rpi_core_type;

   rpi_link_type         l;
   rpi_link_type         next_l;
   rpi_core_type         c;
   rpi_core_type         next_c;
   rpi_pkg::rpi_cfg_type cfg_l;

   // ------------------------------------------------------------
   // register read mux
   // ------------------------------------------------------------
   function automatic logic [7:0] reg_read(input rpi_link_type s);
      logic [7:0] v;
      v = rpi_pkg::REG_RESET;
      unique case (s.ptr)
         rpi_pkg::REG_TCNT0: v = s.tcnt0;
         rpi_pkg::REG_TCNT1: v = s.tcnt1;
         rpi_pkg::REG_EXT:   v = s.ext;
         rpi_pkg::REG_FLAG: begin
            v[rpi_pkg::FLAG_UF] = s.uflag;
            v[rpi_pkg::FLAG_TF] = s.tflag;
         end
         rpi_pkg::REG_CTRL:  v = s.ctrl;
         default:            v = rpi_pkg::REG_RESET;
      endcase
      return v;
   endfunction

   // pure bit selects of link flops, so the crossing sees no glitches
   always_comb begin
      cfg_l.te     = l.ext[rpi_pkg::EXT_TE];
      cfg_l.timer_irq_enable    = l.ctrl[rpi_pkg::CTRL_TIE];
      cfg_l.update_irq_enable    = l.ctrl[rpi_pkg::CTRL_UIE];
      cfg_l.update_period_select   = l.ext[rpi_pkg::EXT_UPDATE_PERIOD_SELECT];
      cfg_l.tsel   = rpi_pkg::rpi_src_type'(l.ext[rpi_pkg::EXT_TSEL +: 2]);
      cfg_l.srst   = l.ctrl[rpi_pkg::CTRL_SRST];
      cfg_l.preset = {l.tcnt1[3:0] & rpi_pkg::PRESET_HI, l.tcnt0};
   end

   // ------------------------------------------------------------
   // link domain: bus slave and registers
   // ------------------------------------------------------------
   always_comb begin
      logic       start;
      logic       stop;
      logic       rise;
      logic       fall;
      logic [7:0] b;
      logic [7:0] rd;
      logic       tset;
      logic       uset;
      start = 1'b0;
      stop  = 1'b0;
      rise  = 1'b0;
      fall  = 1'b0;
      b     = 8'h00;
      rd    = 8'h00;
      tset  = 1'b0;
      uset  = 1'b0;
      next_l = l;
      next_l.rst_m = rst;
      next_l.rst_s = l.rst_m;
      next_l.scl_m = scl_in;
      next_l.scl_s = l.scl_m;
      next_l.scl_d = l.scl_s;
      next_l.sda_m = sda_in;
      next_l.sda_s = l.sda_m;
      next_l.sda_d = l.sda_s;
      next_l.tev_m = c.tev_tgl;
      next_l.tev_s = l.tev_m;
      next_l.tev_d = l.tev_s;
      next_l.uev_m = c.uev_tgl;
      next_l.uev_s = l.uev_m;
      next_l.uev_d = l.uev_s;
      start = l.scl_s & l.scl_d & l.sda_d & ~l.sda_s;
      stop  = l.scl_s & l.scl_d & ~l.sda_d & l.sda_s;
      rise  = l.scl_s & ~l.scl_d;
      fall  = ~l.scl_s & l.scl_d;
      b     = {l.sh[6:0], l.sda_s};
      rd    = reg_read(l);
      tset  = l.tev_s ^ l.tev_d;
      uset  = l.uev_s ^ l.uev_d;
      if (start) begin
         next_l.st    = rpi_pkg::ST_ADDR;
         next_l.bc    = 4'h0;
         next_l.drv   = 1'b0;
         next_l.ackon = 1'b0;
      end else if (stop) begin
         next_l.st  = rpi_pkg::ST_IDLE;
         next_l.drv = 1'b0;
      end else begin
         unique case (l.st)
            rpi_pkg::ST_IDLE: next_l.drv = 1'b0;
            rpi_pkg::ST_ADDR, rpi_pkg::ST_PTR, rpi_pkg::ST_WDATA: begin
               if (rise) begin
                  next_l.sh = b;
                  next_l.bc = l.bc + BIT_ONE;
                  if (l.bc == BIT_END) begin
                     next_l.st    = rpi_pkg::ST_ACK;
                     next_l.ackon = 1'b0;
                     next_l.nxt   = rpi_pkg::ST_WDATA;
                     if (l.st == rpi_pkg::ST_ADDR) begin
                        next_l.rw  = b[0];
                        next_l.nxt = b[0] ? rpi_pkg::ST_RDATA : rpi_pkg::ST_PTR;
                        if (b[7:1] != ADDR7)
                           next_l.st = rpi_pkg::ST_IDLE;
                     end else if (l.st == rpi_pkg::ST_PTR) begin
                        next_l.ptr = b[3:0];
                     end else begin
                        // write takes effect on the rise that samples bit 0
                        next_l.ptr = l.ptr + rpi_pkg::PTR_STEP;
                        unique case (l.ptr)
                           rpi_pkg::REG_TCNT0: next_l.tcnt0 = b;
                           rpi_pkg::REG_TCNT1: next_l.tcnt1 = b;
                           rpi_pkg::REG_EXT: begin
                              next_l.ext = b;
                              if (~l.ext[rpi_pkg::EXT_TE] & b[rpi_pkg::EXT_TE])
                                 next_l.stg = ~l.stg;
                           end
                           rpi_pkg::REG_FLAG: begin
                              next_l.tflag = l.tflag & b[rpi_pkg::FLAG_TF];
                              next_l.uflag = l.uflag & b[rpi_pkg::FLAG_UF];
                           end
                           rpi_pkg::REG_CTRL: next_l.ctrl = b & rpi_pkg::CTRL_MASK;
                           default: next_l.ptr = l.ptr + rpi_pkg::PTR_STEP;
                        endcase
                     end
                  end
               end
            end
            rpi_pkg::ST_ACK: begin
               if (fall && !l.ackon) begin
                  next_l.drv   = 1'b1;
                  next_l.ackon = 1'b1;
               end else if (fall) begin
                  next_l.drv   = 1'b0;
                  next_l.ackon = 1'b0;
                  next_l.bc    = 4'h0;
                  next_l.st    = l.nxt;
                  if (l.nxt == rpi_pkg::ST_RDATA) begin
                     next_l.sh  = rd;
                     next_l.drv = ~rd[7];
                     next_l.ptr = l.ptr + rpi_pkg::PTR_STEP;
                  end
               end
            end
            rpi_pkg::ST_RDATA: begin
               if (rise) begin
                  next_l.bc = l.bc + BIT_ONE;
                  if (l.bc == BIT_END) begin
                     next_l.st    = rpi_pkg::ST_RACK;
                     next_l.ackon = 1'b0;
                  end
               end else if (fall) begin
                  next_l.sh  = {l.sh[6:0], 1'b0};
                  next_l.drv = ~l.sh[6];
               end
            end
            rpi_pkg::ST_RACK: begin
               if (rise) begin
                  next_l.ackon = ~l.sda_s;
                  if (l.sda_s)
                     next_l.st = rpi_pkg::ST_IDLE;
               end else if (fall && l.ackon) begin
                  next_l.st    = rpi_pkg::ST_RDATA;
                  next_l.bc    = 4'h0;
                  next_l.sh    = rd;
                  next_l.drv   = ~rd[7];
                  next_l.ptr   = l.ptr + rpi_pkg::PTR_STEP;
                  next_l.ackon = 1'b0;
               end else if (fall) begin
                  next_l.drv = 1'b0;
               end
            end
            default: next_l.st = rpi_pkg::ST_IDLE;
         endcase
      end
      // a set arriving with a clear wins
      next_l.tflag = next_l.tflag | tset;
      next_l.uflag = next_l.uflag | uset;
      if (l.rst_s) begin
         next_l       = '0;
         next_l.rst_m = rst;
         next_l.rst_s = l.rst_m;
      end
   end

   always_ff @(posedge link_clk) begin
      l <= next_l;
   end

   // ------------------------------------------------------------
   // core domain: source clocks, countdown, interrupt pin
   // ------------------------------------------------------------
   always_comb begin
      logic tick;
      logic e64;
      logic esec;
      logic emin;
      logic src;
      logic start;
      logic tev;
      logic uev;
      start = 1'b0;
      tick  = 1'b0;
      e64   = 1'b0;
      esec  = 1'b0;
      emin  = 1'b0;
      src   = 1'b0;
      tev   = 1'b0;
      uev   = 1'b0;
      next_c = c;
      next_c.cfg_m = cfg_l;
      next_c.cfg_s = c.cfg_m;
      next_c.stg_m = l.stg;
      next_c.stg_s = c.stg_m;
      next_c.stg_d = c.stg_s;
      start = c.stg_s ^ c.stg_d;
      // the 4096 Hz tick keeps running under soft reset
      next_c.tick_cnt = c.tick_cnt + 12'h001;
      if (c.tick_cnt == TDIV_M1) begin
         next_c.tick_cnt = 12'h000;
         tick = 1'b1;
      end
      if (tick) begin
         next_c.t64_cnt = c.t64_cnt + 6'h01;
         next_c.sec_cnt = c.sec_cnt + 13'h0001;
         e64 = (c.t64_cnt == T64_M1);
         esec = (c.sec_cnt == SEC_M1);
         if (e64)
            next_c.t64_cnt = 6'h00;
         if (esec) begin
            next_c.sec_cnt = 13'h0000;
            next_c.min_cnt = c.min_cnt + 6'h01;
            emin = (c.min_cnt == MIN_M1);
            if (emin)
               next_c.min_cnt = 6'h00;
         end
      end
      if (c.cfg_s.srst) begin
         next_c.t64_cnt = 6'h00;
         next_c.sec_cnt = 13'h0000;
         next_c.min_cnt = 6'h00;
         e64  = 1'b0;
         esec = 1'b0;
         emin = 1'b0;
      end
      unique case (c.cfg_s.tsel)
         rpi_pkg::SRC_4096: src = tick;
         rpi_pkg::SRC_64:   src = e64;
         rpi_pkg::SRC_SEC:  src = esec;
         rpi_pkg::SRC_MIN:  src = emin;
      endcase
      // free-running source, so the first period may be short
      if (start) begin
         next_c.cnt = c.cfg_s.preset;
      end else if (c.cfg_s.te && src && c.cnt != 12'h000) begin
         next_c.cnt = c.cnt - CNT_ONE;
         if (c.cnt == CNT_ONE) begin
            tev = 1'b1;
            next_c.cnt = c.cfg_s.preset;
         end
      end
      if (tev && c.cfg_s.timer_irq_enable) begin
         next_c.tmr_low = 1'b1;
         next_c.tmr_rel = (c.cfg_s.tsel == rpi_pkg::SRC_4096) ? RL_FAST : RL_SLOW;
      end else if (c.tmr_low) begin
         next_c.tmr_rel = c.tmr_rel - RL_ONE;
         if (c.tmr_rel == RL_ONE)
            next_c.tmr_low = 1'b0;
         if (!c.cfg_s.timer_irq_enable)
            next_c.tmr_low = 1'b0;
         if (!c.cfg_s.te)
            next_c.tmr_low = 1'b0;
      end
      // update events run even when masked, so the flag keeps setting
      uev = c.cfg_s.update_period_select ? emin : esec;
      if (uev && c.cfg_s.update_irq_enable) begin
         next_c.upd_low = 1'b1;
         next_c.upd_rel = RL_UPD;
      end else if (c.upd_low) begin
         next_c.upd_rel = c.upd_rel - RL_ONE;
         if (c.upd_rel == RL_ONE)
            next_c.upd_low = 1'b0;
         if (!c.cfg_s.update_irq_enable)
            next_c.upd_low = 1'b0;
      end
      next_c.tev_tgl = c.tev_tgl ^ tev;
      next_c.uev_tgl = c.uev_tgl ^ uev;
      if (rst)
         next_c = '0;
   end

   always_ff @(posedge core_clk) begin
      c <= next_c;
   end

   // ------------------------------------------------------------
   // pins
   // ------------------------------------------------------------
   // flag clears never touch the low drive; only enables and timers do
   assign int_out  = 1'b0;
   assign int_oe_n = ~(c.tmr_low | c.upd_low);
   assign sda_out  = 1'b0;
   assign sda_oe_n = ~l.drv;
endmodule
